// ---- core/adc_result_threshold_alarm.sv ----
// ADC result registers and threshold alarms behind an AHB-Lite slave
// Function
// - The result is a 13-bit two's complement value split into a high byte and a low register.
// - The low register keeps the five lowest result bits in its upper field.
// - Reading the high byte latches the matching low bits into the low register.
// - While a single-shot conversion runs the result is marked not valid.
// - The low register is read-only and holds no meaningful bits until the high byte is read after a conversion.
// - The overflow flag is 1 for a sample that overflowed and 0 otherwise.
// - The top eight sample bits above the upper limit (reset FF) raise the upper alarm.
// - The top eight sample bits below the lower limit (reset 00) raise the lower alarm.
// - No alarm is raised while the input buffer is differential.
// - Temperature samples come in the same signed format as any other input.
// - Alarm status bits are set by hardware and cleared by writing 1; writing 0 keeps them.
// - Each alarm has its own interrupt enable; status still sets while disabled.
// - In repeated conversion the registers hold the latest finished conversion.
// - Buffer codes 100 and 101 are differential and silence the alarms.
`timescale 1ns/1ps
`include "adc_alarm_params.svh"

module adc_result_threshold_alarm
    import adc_alarm_pkg::*;
(
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // AHB-Lite slave
    input wire logic hsel_in,
    input wire logic [15:0] haddr_in,
    input wire logic [1:0] htrans_in,
    input wire logic hwrite_in,
    input wire logic [2:0] hsize_in,
    input wire logic [31:0] hwdata_in,
    input wire logic hready_in,
    output logic [31:0] hrdata_out,
    output logic hreadyout_out,
    output logic hresp_out,
    // Converter side
    input wire logic sample_done_in,
    input wire logic [12:0] sample_data_in,
    input wire logic sample_overflow_in,
    input wire logic conv_busy_in,
    output logic repeat_conversion_select_out,
    output logic [2:0] input_buffer_select_out,
    // Interrupt
    output logic irq_out
);

    ////////////////////////////////////////////////////////////////////////////
    // Reset release
    // Reset takes hold at once but leaves through two flops, so no register
    // sees its release close to a clock edge

    logic rst_meta_q;
    logic rst_sync_q;

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rst_meta_q <= 1'b0;
            rst_sync_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_sync_q <= rst_meta_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Bus front end

    reg_req_t req;
    logic rd_addr_take;
    logic wr_upper;
    logic wr_lower;
    logic wr_alarm_ctrl;
    logic wr_conv_ctrl;
    logic rd_high;

    // The port's ready flop is the bus ready itself; one more register here would
    // end the data phase before the read data stands
    // The transfer size is not decoded, since every register is one aligned word
    ahb_slave_port u_port (
        .clk_in(clk_in),
        .rst_n_in(rst_sync_q),
        .hsel_in(hsel_in),
        .haddr_in(haddr_in),
        .htrans_in(htrans_in),
        .hwrite_in(hwrite_in),
        .hready_in(hready_in),
        .req_out(req),
        .hreadyout_out(hreadyout_out)
    );

    function automatic logic hit(input reg_req_t r, input logic wr, input logic [11:0] idx);
        hit = r.valid && (r.write == wr) && (r.index == idx);
    endfunction

    assign wr_upper = hit(req, 1'b1, `IDX_UPPER_LIMIT);
    assign wr_lower = hit(req, 1'b1, `IDX_LOWER_LIMIT);
    assign wr_alarm_ctrl = hit(req, 1'b1, `IDX_ALARM_CTRL);
    assign wr_conv_ctrl = hit(req, 1'b1, `IDX_CONV_CTRL);
    assign rd_high = hit(req, 1'b0, `IDX_RESULT_HIGH);

    // A new read's address phase; it clears the old read data
    assign rd_addr_take = hsel_in && hready_in && htrans_in == `HTRANS_NONSEQ && !hwrite_in;

    // No register raises an error, so every transfer ends OKAY
    always_ff @(posedge clk_in or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            hresp_out <= `HRESP_OKAY;
        end else begin
            hresp_out <= `HRESP_OKAY;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Settings

    // Writing the alarm control word also sets both enables and the buffer mode
    logic [7:0] upper_limit_q;
    logic [7:0] lower_limit_q;
    logic upper_en_q;
    logic lower_en_q;

    always_ff @(posedge clk_in or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            upper_limit_q <= `UPPER_LIMIT_RESET;
            lower_limit_q <= `LOWER_LIMIT_RESET;
        end else begin
            if (wr_upper) begin
                upper_limit_q <= hwdata_in[7:0];
            end
            if (wr_lower) begin
                lower_limit_q <= hwdata_in[7:0];
            end
        end
    end

    always_ff @(posedge clk_in or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            upper_en_q <= 1'b0;
            lower_en_q <= 1'b0;
            input_buffer_select_out <= `BUF_MODE_RESET;
        end else if (wr_alarm_ctrl) begin
            upper_en_q <= hwdata_in[`UPPER_ENABLE_BIT];
            lower_en_q <= hwdata_in[`LOWER_ENABLE_BIT];
            input_buffer_select_out <= hwdata_in[`BUF_MODE_MSB:`BUF_MODE_LSB];
        end
    end

    // Repeat select only changes how validity behaves; every done stores a result
    always_ff @(posedge clk_in or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            repeat_conversion_select_out <= 1'b0;
        end else if (wr_conv_ctrl) begin
            repeat_conversion_select_out <= hwdata_in[`CONV_REPEAT_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Result capture

    // Result bits have no defined reset value; zero keeps reads free of unknowns
    sample_t live_q;
    logic [4:0] low_latch_q;
    logic low_ovf_q;
    logic result_valid_q;

    // Every finished conversion overwrites the result, whatever the mode
    always_ff @(posedge clk_in or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            live_q <= '0;
        end else if (sample_done_in) begin
            live_q.data <= sample_data_in;
            live_q.overflow <= sample_overflow_in;
        end
    end

    // In single-shot mode valid drops while a conversion runs; it returns when a conversion ends
    always_ff @(posedge clk_in or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            result_valid_q <= 1'b0;
        end else if (sample_done_in) begin
            result_valid_q <= 1'b1;
        end else if (conv_busy_in && !repeat_conversion_select_out) begin
            result_valid_q <= 1'b0;
        end
    end

    // The low bits follow the high byte only when it is read, so a split read is coherent
    always_ff @(posedge clk_in or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            low_latch_q <= 5'h00;
            low_ovf_q <= 1'b0;
        end else if (rd_high) begin
            low_latch_q <= live_q.data[`RESULT_LSB_COUNT-1:0];
            low_ovf_q <= live_q.overflow;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Alarms and interrupt

    logic upper_hit;
    logic lower_hit;
    logic upper_status_q;
    logic lower_status_q;
    logic clr_upper;
    logic clr_lower;

    // The compare sees the incoming sample, so status sets on the edge that stores it
    alarm_compare u_cmp (
        .sample_in(sample_data_in),
        .upper_limit_in(upper_limit_q),
        .lower_limit_in(lower_limit_q),
        .buf_mode_in(input_buffer_select_out),
        .upper_hit_out(upper_hit),
        .lower_hit_out(lower_hit)
    );

    // Writing a one clears a status bit; a zero leaves it
    assign clr_upper = wr_alarm_ctrl && hwdata_in[`UPPER_STATUS_BIT];
    assign clr_lower = wr_alarm_ctrl && hwdata_in[`LOWER_STATUS_BIT];

    // A hit in the clearing cycle wins over the clear
    always_ff @(posedge clk_in or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            upper_status_q <= 1'b0;
            lower_status_q <= 1'b0;
        end else begin
            if (sample_done_in && upper_hit) begin
                upper_status_q <= 1'b1;
            end else if (clr_upper) begin
                upper_status_q <= 1'b0;
            end
            if (sample_done_in && lower_hit) begin
                lower_status_q <= 1'b1;
            end else if (clr_lower) begin
                lower_status_q <= 1'b0;
            end
        end
    end

    // One cycle behind the status bits, since the output must leave a flip-flop
    always_ff @(posedge clk_in or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            irq_out <= 1'b0;
        end else begin
            irq_out <= (upper_status_q && upper_en_q) || (lower_status_q && lower_en_q);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read data

    // Unused bits of every register read as zero
    logic [7:0] rd_byte;

    always_comb begin
        rd_byte = 8'h00;
        case (req.index)
            `IDX_CONV_CTRL: begin
                rd_byte[`CONV_BUSY_BIT] = conv_busy_in;
                rd_byte[`CONV_REPEAT_BIT] = repeat_conversion_select_out;
                rd_byte[`CONV_VALID_BIT] = result_valid_q;
            end
            `IDX_ALARM_CTRL: begin
                rd_byte[`UPPER_STATUS_BIT] = upper_status_q;
                rd_byte[`LOWER_STATUS_BIT] = lower_status_q;
                rd_byte[`UPPER_ENABLE_BIT] = upper_en_q;
                rd_byte[`LOWER_ENABLE_BIT] = lower_en_q;
                rd_byte[`BUF_MODE_MSB:`BUF_MODE_LSB] = input_buffer_select_out;
            end
            `IDX_RESULT_HIGH: begin
                rd_byte = live_q.data[`RESULT_WIDTH-1:`RESULT_LSB_COUNT];
            end
            `IDX_RESULT_LOW: begin
                rd_byte[`LSB_FIELD_MSB:`LSB_FIELD_LSB] = low_latch_q;
                rd_byte[`OVERFLOW_BIT] = low_ovf_q;
            end
            `IDX_UPPER_LIMIT: begin
                rd_byte = upper_limit_q;
            end
            `IDX_LOWER_LIMIT: begin
                rd_byte = lower_limit_q;
            end
            default: begin
                rd_byte = 8'h00;
            end
        endcase
    end

    always_ff @(posedge clk_in or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            hrdata_out <= 32'h0000_0000;
        end else if (req.valid && !req.write) begin
            hrdata_out <= {24'h00_0000, rd_byte};
        end else if (rd_addr_take) begin
            hrdata_out <= 32'h0000_0000;
        end
    end

endmodule

// ---- core/ahb_slave_port.sv ----
// AHB-Lite slave front end: takes the address phase and inserts one wait state
`timescale 1ns/1ps
`include "adc_alarm_params.svh"

module ahb_slave_port
    import adc_alarm_pkg::*;
(
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // AHB-Lite address phase
    input wire logic hsel_in,
    input wire logic [15:0] haddr_in,
    input wire logic [1:0] htrans_in,
    input wire logic hwrite_in,
    input wire logic hready_in,
    // Towards the register file
    output reg_req_t req_out,
    output logic hreadyout_out
);

    bus_phase_t phase_q;
    logic write_q;
    logic [11:0] index_q;
    logic mapped_q;

    // Words only; the two low address bits are ignored
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            phase_q <= PH_IDLE;
            write_q <= 1'b0;
            index_q <= 12'h000;
            mapped_q <= 1'b0;
        end else begin
            case (phase_q)
                PH_IDLE: begin
                    if (hsel_in && hready_in && htrans_in == `HTRANS_NONSEQ) begin
                        phase_q <= PH_WAIT;
                        write_q <= hwrite_in;
                        index_q <= haddr_in[13:2];
                        mapped_q <= (haddr_in[15:14] == 2'h0);
                    end
                end
                PH_WAIT: begin
                    phase_q <= PH_IDLE;
                end
                default: begin
                    phase_q <= PH_IDLE;
                end
            endcase
        end
    end

    // Ready is low exactly in the cycle after an accepted address phase
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            hreadyout_out <= 1'b1;
        end else begin
            hreadyout_out <= !(phase_q == PH_IDLE && hsel_in && hready_in
                               && htrans_in == `HTRANS_NONSEQ);
        end
    end

    always_comb begin
        req_out.valid = (phase_q == PH_WAIT) && mapped_q;
        req_out.write = write_q;
        req_out.index = index_q;
    end

endmodule

// ---- core/alarm_compare.sv ----
// Threshold comparison of one sample against the upper and lower limits
`timescale 1ns/1ps
`include "adc_alarm_params.svh"

module alarm_compare
    import adc_alarm_pkg::*;
(
    // Sample and setup
    input wire logic [12:0] sample_in,
    input wire logic [7:0] upper_limit_in,
    input wire logic [7:0] lower_limit_in,
    input wire logic [2:0] buf_mode_in,
    // Alarm hits
    output logic upper_hit_out,
    output logic lower_hit_out
);

    logic [7:0] top8;
    logic differential;

    assign top8 = sample_in[12:5];
    assign differential = (buf_mode_in == BUF_DIFF_UNBUFFERED)
                          || (buf_mode_in == BUF_DIFF_UNITY);

    // Unsigned byte compare, so the reset limits of FF and 00 never trip
    assign upper_hit_out = !differential && (top8 > upper_limit_in);
    assign lower_hit_out = !differential && (top8 < lower_limit_in);

endmodule

// ---- inc/adc_alarm_params.svh ----
// Offsets, field positions, reset values and bus constants of the ADC result and alarm block
`ifndef ADC_ALARM_PARAMS_SVH
`define ADC_ALARM_PARAMS_SVH

// Register indices; the byte address on the bus is four times the index
`define IDX_CONV_CTRL 12'hF70
`define IDX_ALARM_CTRL 12'hF71
`define IDX_RESULT_HIGH 12'hF72
`define IDX_RESULT_LOW 12'hF73
`define IDX_UPPER_LIMIT 12'hF74
`define IDX_LOWER_LIMIT 12'hF76

// Conversion control fields
`define CONV_BUSY_BIT 7
`define CONV_REPEAT_BIT 4
`define CONV_VALID_BIT 0

// Alarm control / status fields
`define UPPER_STATUS_BIT 6
`define LOWER_STATUS_BIT 5
`define UPPER_ENABLE_BIT 4
`define LOWER_ENABLE_BIT 3
`define BUF_MODE_MSB 2
`define BUF_MODE_LSB 0

// Low result register fields
`define LSB_FIELD_MSB 7
`define LSB_FIELD_LSB 3
`define OVERFLOW_BIT 0

// Reset values
`define UPPER_LIMIT_RESET 8'hFF
`define LOWER_LIMIT_RESET 8'h00
`define BUF_MODE_RESET 3'h0

// Result layout
`define RESULT_WIDTH 13
`define RESULT_LSB_COUNT 5

// AHB transfer type and response codes
`define HTRANS_NONSEQ 2'h2
`define HRESP_OKAY 1'h0

`endif

// ---- inc/adc_alarm_pkg.sv ----
// Types shared by the ADC result and alarm block
package adc_alarm_pkg;

    // One register access taken from the bus, valid for one cycle
    typedef struct packed {
        logic valid;
        logic write;
        logic [11:0] index;
    } reg_req_t;

    // One completed conversion from the converter
    typedef struct packed {
        logic [12:0] data;
        logic overflow;
    } sample_t;

    // Input buffer modes; the differential codes silence the alarms
    typedef enum logic [2:0] {
        BUF_SE_UNBUFFERED = 3'b000,
        BUF_SE_UNITY = 3'b001,
        BUF_DIFF_UNBUFFERED = 3'b100,
        BUF_DIFF_UNITY = 3'b101
    } buffer_mode_t;

    // Bus slave phase
    typedef enum logic [0:0] {
        PH_IDLE = 1'b0,
        PH_WAIT = 1'b1
    } bus_phase_t;

endpackage

// ---- tb/adc_alarm_monitor.sv ----
// Port-level bus timing and alarm interrupt checks for the ADC result block
`timescale 1ns/1ps

module adc_alarm_monitor (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // Bus and converter inputs
    input wire logic hsel_in,
    input wire logic [1:0] htrans_in,
    input wire logic hready_in,
    input wire logic sample_done_in,
    // Outputs watched
    input wire logic [31:0] hrdata_out,
    input wire logic hreadyout_out,
    input wire logic hresp_out,
    input wire logic [2:0] input_buffer_select_out,
    input wire logic irq_out
);
    default clocking dcb @(posedge clk_in);
    endclocking
    default disable iff (!rst_n_in);

    sequence bus_take;
        hsel_in && hready_in && htrans_in == 2'h2;
    endsequence
    sequence one_wait;
        !hreadyout_out ##1 hreadyout_out;
    endsequence

    resp_okay_a: assert property (hresp_out == 1'h0)
        else $error("Response is not OKAY");
    wait_state_a: assert property (bus_take |=> one_wait)
        else $error("Transfer did not see exactly one wait state");
    ready_cause_a: assert property ($fell(hreadyout_out) |-> $past(hsel_in))
        else $error("Wait state without a transfer");
    rdata_upper_a: assert property (hrdata_out[31:8] == 24'h0)
        else $error("Read data upper bits not zero");
    rdata_hold_a: assert property ($changed(hrdata_out)
        |-> !hreadyout_out || $past(hreadyout_out) == 1'h0)
        else $error("Read data changed outside a read");
    // A write or sample lands one edge before the interrupt flop moves, two before it is seen
    irq_rise_a: assert property ($rose(irq_out)
        |-> $past(sample_done_in, 2) || $past(hreadyout_out, 2) == 1'h0)
        else $error("Interrupt rose without a sample or write");
    irq_fall_a: assert property ($fell(irq_out) |-> $past(hreadyout_out, 2) == 1'h0)
        else $error("Interrupt fell without a write");
    diff_quiet_a: assert property (sample_done_in
        && input_buffer_select_out[2:1] == 2'h2 && hreadyout_out && $past(hreadyout_out)
        && !irq_out |-> ##2 !irq_out)
        else $error("Alarm raised in differential mode");
endmodule

bind adc_result_threshold_alarm adc_alarm_monitor i_adc_alarm_monitor (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .hsel_in(hsel_in),
    .htrans_in(htrans_in),
    .hready_in(hready_in),
    .sample_done_in(sample_done_in),
    .hrdata_out(hrdata_out),
    .hreadyout_out(hreadyout_out),
    .hresp_out(hresp_out),
    .input_buffer_select_out(input_buffer_select_out),
    .irq_out(irq_out)
);

// ---- tb/test_adc_result_threshold_alarm.sv ----
// Self-checking bench for the ADC result and threshold alarm block
`timescale 1ns/1ps
`include "adc_alarm_params.svh"

module test_adc_result_threshold_alarm;
    logic clk_in = 1'h0;
    logic rst_n_in = 1'h0;
    logic hsel = 1'h0;
    logic hwrite = 1'h0;
    logic done = 1'h0;
    logic ovf = 1'h0;
    logic busy = 1'h0;
    logic [1:0] htrans = 2'h0;
    logic [15:0] haddr = 16'h0;
    logic [31:0] hwdata = 32'h0;
    logic [12:0] sdata = 13'h0;
    logic [31:0] hrdata, rd;
    logic hrdy, hresp, rep, irq;
    logic [2:0] bufm, md;
    logic [7:0] ul, ll;
    logic ue, le, us, ls, o;
    logic [12:0] a, b, c, w;
    logic [31:0] lf = 32'hD8B0;
    int errors = 0;
    int num_checks = 0;

    adc_result_threshold_alarm i_adc_result_threshold_alarm (
        .clk_in(clk_in), .rst_n_in(rst_n_in),
        .hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite),
        .hsize_in(3'h2), .hwdata_in(hwdata), .hready_in(hrdy), .hrdata_out(hrdata),
        .hreadyout_out(hrdy), .hresp_out(hresp),
        .sample_done_in(done), .sample_data_in(sdata), .sample_overflow_in(ovf),
        .conv_busy_in(busy), .repeat_conversion_select_out(rep),
        .input_buffer_select_out(bufm), .irq_out(irq)
    );

    initial begin
        forever #20 clk_in = ~clk_in;
    end

    function automatic void step();
        lf = {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
    endfunction

    task chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Entered just after a rising edge; leaves just after the edge that ends the data phase
    task bus(input logic wr, input logic [11:0] idx, input logic [31:0] wd);
        hsel <= 1'h1;
        haddr <= {2'h0, idx, 2'h0};
        htrans <= 2'h2;
        hwrite <= wr;
        @(posedge clk_in);
        while (hrdy !== 1'h1) @(posedge clk_in);
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge clk_in);
        while (hrdy !== 1'h1) @(posedge clk_in);
        rd = hrdata;
    endtask

    task rdc(input logic [11:0] idx, input logic [31:0] exp);
        bus(1'h0, idx, 32'h0);
        chk(rd, exp);
    endtask

    function automatic void hit(input logic [12:0] d);
        if (!md[2]) begin
            us |= d[12:5] > ul;
            ls |= d[12:5] < ll;
        end
    endfunction

    // One sample, or two on consecutive edges; the second carries the overflow flag
    task smp(input logic [12:0] d0, input logic [12:0] d1, input logic two);
        done <= 1'h1;
        sdata <= d0;
        ovf <= 1'h0;
        @(posedge clk_in);
        hit(d0);
        if (two) begin
            sdata <= d1;
            ovf <= 1'h1;
            @(posedge clk_in);
            hit(d1);
        end
        done <= 1'h0;
        sdata <= ~sdata;
        ovf <= ~ovf;
    endtask

    task print_verdict();
        $display("Checks %0d, errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk_in);
        errors++;
        print_verdict();
    end

    initial begin
        repeat (2) @(posedge clk_in);
        rst_n_in <= 1'h1;
        repeat (3) @(posedge clk_in);
        chk({28'h0, rep, bufm}, 32'h0);
        chk({31'h0, irq}, 32'h0);
        rdc(`IDX_UPPER_LIMIT, 32'hFF);
        rdc(`IDX_LOWER_LIMIT, 32'h0);
        rdc(`IDX_ALARM_CTRL, 32'h0);
        bus(1'h1, `IDX_RESULT_LOW, 32'hFF);
        bus(1'h1, 12'h123, 32'h55);
        rdc(12'h123, 32'h0);
        busy <= 1'h1;
        bus(1'h1, `IDX_CONV_CTRL, 32'h10);
        chk({31'h0, rep}, 32'h1);
        bus(1'h1, `IDX_CONV_CTRL, 32'h0);
        rdc(`IDX_CONV_CTRL, 32'h80);
        busy <= 1'h0;
        rdc(`IDX_RESULT_LOW, 32'h0);
        us = 1'h0;
        ls = 1'h0;
        ul = 8'hFF;
        ll = 8'h00;
        md = 3'h1;
        // Sensor-style sample: single-ended unity gain, positive value, reset limits
        bus(1'h1, `IDX_ALARM_CTRL, 32'h1);
        smp(13'h0A5C, 13'h0, 1'h0);
        rdc(`IDX_RESULT_HIGH, 32'h52);
        rdc(`IDX_RESULT_LOW, 32'hE0);
        rdc(`IDX_ALARM_CTRL, 32'h1);
        for (int i = 0; i < 40; i++) begin
            step();
            ul = lf[7:0];
            ll = lf[15:8];
            md = {lf[16], 1'h0, lf[17]};
            ue = lf[18];
            le = lf[19];
            bus(1'h1, `IDX_UPPER_LIMIT, {24'h0, ul});
            bus(1'h1, `IDX_LOWER_LIMIT, {24'h0, ll});
            bus(1'h1, `IDX_ALARM_CTRL, {27'h0, ue, le, md});
            chk({29'h0, bufm}, {29'h0, md});
            step();
            // Equal to the upper limit must not alarm
            a = lf[21] ? {ul, lf[4:0]} : lf[12:0];
            b = lf[25:13];
            o = lf[26];
            w = o ? b : a;
            smp(a, b, o);
            rdc(`IDX_RESULT_HIGH, {24'h0, w[12:5]});
            step();
            c = lf[12:0];
            smp(c, c, 1'h0);
            rdc(`IDX_RESULT_LOW, {24'h0, w[4:0], 2'h0, o});
            rdc(`IDX_ALARM_CTRL, {25'h0, us, ls, ue, le, md});
            chk({31'h0, irq}, {31'h0, (us & ue) | (ls & le)});
            step();
            bus(1'h1, `IDX_ALARM_CTRL, {25'h0, lf[1:0], ue, le, md});
            us &= !lf[1];
            ls &= !lf[0];
            rdc(`IDX_ALARM_CTRL, {25'h0, us, ls, ue, le, md});
            chk({31'h0, irq}, {31'h0, (us & ue) | (ls & le)});
            bus(1'h1, `IDX_ALARM_CTRL, {25'h0, 2'h3, ue, le, md});
            us = 1'h0;
            ls = 1'h0;
        end
        rdc(`IDX_CONV_CTRL, 32'h1);
        busy <= 1'h1;
        rdc(`IDX_CONV_CTRL, 32'h80);
        busy <= 1'h0;
        bus(1'h1, `IDX_UPPER_LIMIT, 32'h5A);
        // A reset in mid-run must bring the upper limit back and leave the valid flag clear
        rst_n_in <= 1'h0;
        repeat (2) @(posedge clk_in);
        rst_n_in <= 1'h1;
        repeat (3) @(posedge clk_in);
        rdc(`IDX_UPPER_LIMIT, 32'hFF);
        rdc(`IDX_CONV_CTRL, 32'h0);
        print_verdict();
    end
endmodule
